/* hdl/chipsel_port.sv */
`timescale 1ns/1ps
`include "chipsel_port_map.svh"
module chipsel_port
  import chipsel_port_pkg::*;
#(
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Special-function register access from the core
  input wire sfr_req_type sfrReq,
  output logic [7:0] sfrRdata,
  // External data bus cycle from the core
  input wire ext_bus_type extBus,
  // Port pins
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe,
  // Reboot request from the highest pin, active high
  output logic rebootRequest
);

  logic [1:0] rstPipe_r;
  wire logic rstSyncN = rstPipe_r[1];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end

  logic [7:0] cfgFirst_r;
  logic [7:0] cfgSecond_r;
  logic [7:0] polarity_r;
  logic [3:0] portData_r;
  logic [7:0] cmpLow_r [PINS];
  logic [7:0] cmpHigh_r [PINS];
  logic [PINS-1:0] pinMeta_r;
  logic [PINS-1:0] pinSync_r;

  // Pins arrive from outside the clock domain
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinMeta_r <= '1;
      pinSync_r <= '1;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  wire logic wrCfgFirst = sfrReq.write && sfrReq.addr == `ADDR_CFG_FIRST;
  wire logic wrCfgSecond = sfrReq.write && sfrReq.addr == `ADDR_CFG_SECOND;
  wire logic wrPolarity = sfrReq.write && sfrReq.addr == `ADDR_POLARITY;
  wire logic wrPortData = sfrReq.write && sfrReq.addr == `ADDR_PORT_DATA;

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cfgFirst_r <= `CFG_RESET; // R1
      cfgSecond_r <= `CFG_RESET; // R1
      polarity_r <= `POLARITY_RESET;
      portData_r <= `PORT_DATA_RESET;
    end else begin
      if (wrCfgFirst) cfgFirst_r <= sfrReq.wdata; // R6
      if (wrCfgSecond) cfgSecond_r <= sfrReq.wdata; // R6
      if (wrPolarity) polarity_r <= sfrReq.wdata;
      if (wrPortData) portData_r <= sfrReq.wdata[3:0]; // R7
    end
  end

  // Compare address byte offsets, one pair per pin
  localparam logic [7:0] LOW_ADDR [4] = '{`ADDR_CMP0_LOW, `ADDR_CMP1_LOW,
                                          `ADDR_CMP2_LOW, `ADDR_CMP3_LOW};
  localparam logic [7:0] HIGH_ADDR [4] = '{`ADDR_CMP0_HIGH, `ADDR_CMP1_HIGH,
                                           `ADDR_CMP2_HIGH, `ADDR_CMP3_HIGH};

  wire pin_cfg_type pinCfg [PINS];
  wire logic [PINS-1:0] strobeActive;
  wire logic [PINS-1:0] invert = polarity_r[`POLARITY_LSB +: PINS];
  logic [PINS-1:0] pinOut_nxt;
  logic [PINS-1:0] pinOe_nxt;

  genvar p;
  generate
    for (p = 0; p < PINS; p = p + 1) begin : pinSlice
      wire logic wrLow = sfrReq.write && sfrReq.addr == LOW_ADDR[p];
      wire logic wrHigh = sfrReq.write && sfrReq.addr == HIGH_ADDR[p];

      always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
          cmpLow_r[p] <= `CMP_RESET;
          cmpHigh_r[p] <= `CMP_RESET;
        end else begin
          if (wrLow) cmpLow_r[p] <= sfrReq.wdata; // R5
          if (wrHigh) cmpHigh_r[p] <= sfrReq.wdata; // R5
        end
      end

      // Pins 0 and 1 live in the first register, 2 and 3 in the second
      assign pinCfg[p] = (p < 2) ? pin_cfg_type'(cfgFirst_r[(p % 2) * 4 +: 4])
                                 : pin_cfg_type'(cfgSecond_r[(p % 2) * 4 +: 4]); // R6

      strobe_decoder decode (
        .cfg(pinCfg[p]),
        .compareAddr({cmpHigh_r[p], cmpLow_r[p]}),
        .bus(extBus),
        .strobeActive(strobeActive[p])
      );

      // Strobe modes drive hard; plain I/O pulls low hard and lets the pull-up lift it
      always_comb begin
        if (pinCfg[p].mode == MODE_GPIO) begin
          pinOut_nxt[p] = 1'b0; // R1
          pinOe_nxt[p] = ~portData_r[p]; // R7
        end else begin
          pinOut_nxt[p] = strobeActive[p] ^ ~invert[p]; // R10 R11
          pinOe_nxt[p] = 1'b1;
        end
      end
    end
  endgenerate

  // Reboot request only counts while the pin is not driven by a strobe
  wire logic rebootPinFree = pinCfg[`REBOOT_PIN].mode == MODE_GPIO;
  wire logic rebootReq_nxt = rebootPinFree & ~pinSync_r[`REBOOT_PIN]; // R8

  logic [7:0] readMux;
  always_comb begin
    readMux = `READ_UNMAPPED;
    case (sfrReq.addr)
      `ADDR_CFG_FIRST: readMux = cfgFirst_r;
      `ADDR_CFG_SECOND: readMux = cfgSecond_r;
      `ADDR_POLARITY: readMux = polarity_r;
      `ADDR_PORT_DATA: readMux = {4'hF, pinSync_r}; // R7
      `ADDR_CMP0_LOW: readMux = cmpLow_r[0];
      `ADDR_CMP0_HIGH: readMux = cmpHigh_r[0];
      `ADDR_CMP1_LOW: readMux = cmpLow_r[1];
      `ADDR_CMP1_HIGH: readMux = cmpHigh_r[1];
      `ADDR_CMP2_LOW: readMux = cmpLow_r[2];
      `ADDR_CMP2_HIGH: readMux = cmpHigh_r[2];
      `ADDR_CMP3_LOW: readMux = cmpLow_r[3];
      `ADDR_CMP3_HIGH: readMux = cmpHigh_r[3];
      default: readMux = `READ_UNMAPPED;
    endcase
  end

  // Outputs registered; strobes lag the external strobes by one clock
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinOut <= '0;
      pinOe <= '0;
      rebootRequest <= 1'b0;
      sfrRdata <= 8'h00;
    end else begin
      pinOut <= pinOut_nxt; // R2 R3 R4
      pinOe <= pinOe_nxt;
      rebootRequest <= rebootReq_nxt;
      sfrRdata <= sfrReq.read ? readMux : 8'h00;
    end
  end

endmodule : chipsel_port

/* hdl/chipsel_port_map.svh */
// Overview of operation
// R1 - After reset all four pins run in mode 0 as quasi-bidirectional general-purpose I/O.
// R2 - Mode 1 drives a read strobe that follows the external read strobe when the address hits.
// R3 - Mode 2 drives a write strobe that follows the external write strobe when the address hits.
// R4 - Mode 3 drives a strobe that follows either external strobe when the address hits.
// R5 - Each pin holds its own 16-bit compare address as a high and a low byte register.
// R6 - The mode of each pin comes from software-written bits in two configuration registers.
// R7 - The 4-bit port data register sits at 0xA5 and its writes drive pins used as plain I/O.
// R8 - The highest pin also serves as an input that requests a hardware reboot.
// R9 - The configuration registers can mask the lowest address lines out of the comparison.
// R10 - A per-pin invert bit set to 1 turns that pin's strobe to positive polarity.
// R11 - An uninverted strobe is active low and follows the matching external strobe interval.
`ifndef CHIPSEL_PORT_MAP_SVH
`define CHIPSEL_PORT_MAP_SVH

`define ADDR_CFG_FIRST 8'h92
`define ADDR_CFG_SECOND 8'h93
`define ADDR_CMP0_LOW 8'h94
`define ADDR_CMP0_HIGH 8'h95
`define ADDR_CMP1_LOW 8'h96
`define ADDR_CMP1_HIGH 8'h97
`define ADDR_CMP2_LOW 8'h9A
`define ADDR_CMP2_HIGH 8'h9B
`define ADDR_CMP3_LOW 8'h9C
`define ADDR_CMP3_HIGH 8'h9D
`define ADDR_POLARITY 8'hA3
`define ADDR_PORT_DATA 8'hA5

`define CFG_RESET 8'h00
`define CMP_RESET 8'h00
`define POLARITY_RESET 8'h00
`define PORT_DATA_RESET 4'hF
`define READ_UNMAPPED 8'hFF
`define POLARITY_LSB 4
`define REBOOT_PIN 3

`endif

/* hdl/chipsel_port_pkg.sv */
package chipsel_port_pkg;

  typedef enum logic [1:0] {
    MODE_GPIO,
    MODE_READ,
    MODE_WRITE,
    MODE_READ_WRITE
  } pin_mode_type;

  // One nibble of a configuration register: mode above, mask count below
  typedef struct packed {
    pin_mode_type mode;
    logic [1:0] maskCount;
  } pin_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic read;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic [15:0] addr;
    logic rdN;
    logic wrN;
  } ext_bus_type;

endpackage : chipsel_port_pkg

/* hdl/strobe_decoder.sv */
`timescale 1ns/1ps
module strobe_decoder
  import chipsel_port_pkg::*;
(
  // Pin setup
  input wire pin_cfg_type cfg,
  input wire logic [15:0] compareAddr,
  // External bus cycle
  input wire ext_bus_type bus,
  // Decoded strobe, active high
  output logic strobeActive
);

  function automatic logic [15:0] careMask(input logic [1:0] count);
    case (count)
      2'd1: careMask = 16'hFFFE;
      2'd2: careMask = 16'hFFFC;
      2'd3: careMask = 16'hFFF8;
      default: careMask = 16'hFFFF;
    endcase
  endfunction : careMask

  wire logic [15:0] care = careMask(cfg.maskCount); // R9
  wire logic hit = ((bus.addr ^ compareAddr) & care) == 16'h0000; // R5
  wire logic rdActive = ~bus.rdN & hit;
  wire logic wrActive = ~bus.wrN & hit;

  always_comb begin
    case (cfg.mode)
      MODE_READ: strobeActive = rdActive; // R2
      MODE_WRITE: strobeActive = wrActive; // R3
      MODE_READ_WRITE: strobeActive = rdActive | wrActive; // R4
      default: strobeActive = 1'b0;
    endcase
  end

endmodule : strobe_decoder

/* sim/chipsel_port_monitor.sv */
`timescale 1ns/1ps
module chipsel_port_monitor
  import chipsel_port_pkg::*;
#(
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Core side
  input wire sfr_req_type sfrReq,
  input wire logic [7:0] sfrRdata,
  input wire ext_bus_type extBus,
  // Pins
  input wire logic [PINS-1:0] pinIn,
  input wire logic [PINS-1:0] pinOut,
  input wire logic [PINS-1:0] pinOe,
  input wire logic rebootRequest
);
  wire idle = extBus.rdN && extBus.wrN;
  wire rdData = sfrReq.read && sfrReq.addr == 8'hA5;
  wire hole = sfrReq.addr == 8'h80;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_reset_quiet: assert property (disable iff (1'b0) !resetn |-> pinOe == '0)
    else $error("pins driven in reset");
  chk_rd_idle: assert property (!$past(sfrReq.read) |-> sfrRdata == 8'h00)
    else $error("stray read data");
  chk_unmapped_ff: assert property (sfrReq.read && hole |=> sfrRdata == 8'hFF)
    else $error("unmapped read not FF");
  chk_data_upper: assert property (rdData |=> sfrRdata[7:4] == 4'hF)
    else $error("port upper nibble");
  chk_data_pins: assert property (rdData |=> sfrRdata[3:0] == $past(pinIn[3:0], 3))
    else $error("port read not pins");
  chk_reboot_cause: assert property (rebootRequest |-> !$past(pinIn[3], 3))
    else $error("reboot without low pin");
  chk_idle_stable: assert property ($past(idle) && $past(idle, 2) &&
    !$past(sfrReq.write, 2) |-> $stable(pinOut) && $stable(pinOe)) else $error("pins moved");
  chk_unmapped_wr: assert property ($past(idle) && $past(idle, 2) &&
    $past(sfrReq.write && hole, 2) |-> $stable(pinOe)) else $error("hole write acted");
endmodule : chipsel_port_monitor
bind chipsel_port chipsel_port_monitor #(.PINS(PINS)) mon_u (.clock, .resetn, .sfrReq,
  .sfrRdata, .extBus, .pinIn, .pinOut, .pinOe, .rebootRequest);

/* sim/pin_peer.sv */
`timescale 1ns/1ps
module pin_peer (
  // Drive from the port
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  // Boot switch on the top pin
  input wire logic bootLow,
  // Resolved levels
  output logic [3:0] pinIn
);
  // Released pins float up; the switch beats the pull-up only
  assign pinIn = (pinOe & pinOut) | (~pinOe & {~bootLow, 3'b111});
endmodule : pin_peer

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
  import chipsel_port_pkg::*;
  // Both start high so that reset gets a real falling edge before the first rising clock edge
  logic clock = 1;
  logic resetn = 1;
  logic bootLow = 0;
  sfr_req_type sfrReq = '0;
  ext_bus_type extBus = '{16'h0000, 1'b1, 1'b1};
  logic [7:0] sfrRdata;
  logic [3:0] pinIn, pinOut, pinOe;
  logic rebootRequest;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 clock = ~clock;
  chipsel_port #(.PINS(4)) dut_u (.clock, .resetn, .sfrReq, .sfrRdata, .extBus, .pinIn,
    .pinOut, .pinOe, .rebootRequest);
  pin_peer peer_u (.pinOut, .pinOe, .bootLow, .pinIn);
  task results;
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      results();
    end
  end
  task sfr(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(negedge clock) sfrReq = '{a, wr, ~wr, d};
    @(negedge clock) sfrReq = '0;
  endtask : sfr
  task ex(input logic [15:0] a, input logic r, input logic w);
    @(negedge clock) extBus = '{a, r, w};
    @(negedge clock);
  endtask : ex
  task t_reset;
    `CHK(pinOe, 4'h0)
    sfr(8'h80, 8'h00, 1);
    sfr(8'hA5, 8'h00, 0);
    `CHK(sfrRdata, 8'hFF)
    sfr(8'h80, 8'h00, 0);
    `CHK(sfrRdata, 8'hFF)
  endtask : t_reset
  task t_gpio;
    sfr(8'hA5, 8'h0E, 1);
    // Pin drive is registered one edge after the data register takes the write
    @(negedge clock);
    `CHK(pinOe, 4'h1)
    `CHK(pinOut[0], 1'b0)
    repeat (3) @(negedge clock);
    sfr(8'hA5, 8'h00, 0);
    `CHK(sfrRdata, 8'hFE)
    sfr(8'hA5, 8'h0F, 1);
  endtask : t_gpio
  task t_strobe;
    logic hit;
    sfr(8'h94, 8'h34, 1);
    sfr(8'h95, 8'h12, 1);
    sfr(8'h94, 8'h00, 0);
    `CHK(sfrRdata, 8'h34)
    for (int m = 1; m < 4; m++) begin
      sfr(8'h92, {4'h0, m[1:0], 2'b10}, 1);
      for (int k = 0; k < 2; k++) begin
        hit = k[0] ? m[1] : m[0];
        ex(16'h1237, k[0], ~k[0]);
        `CHK(pinOut[0], ~hit)
        ex(16'h1238, k[0], ~k[0]);
        `CHK(pinOut[0], 1'b1)
        ex(16'h1237, 1, 1);
        `CHK(pinOut[0], 1'b1)
        `CHK(pinOe, 4'h1)
      end
    end
    for (int c = 1; c < 4; c += 2) begin
      sfr(8'h92, {4'h0, 2'b10, c[1:0]}, 1);
      ex(16'h1234 ^ (16'h0001 << (c - 1)), 1, 0);
      `CHK(pinOut[0], 1'b0)
      ex(16'h1234 ^ (16'h0001 << c), 1, 0);
      `CHK(pinOut[0], 1'b1)
    end
    sfr(8'h92, 8'h0E, 1);
    sfr(8'hA3, 8'h10, 1);
    ex(16'h1234, 1, 0);
    `CHK(pinOut[0], 1'b1)
    ex(16'h1233, 1, 0);
    `CHK(pinOut[0], 1'b0)
    sfr(8'h9D, 8'hAB, 1);
    sfr(8'h9C, 8'hCD, 1);
    sfr(8'h93, 8'hC0, 1);
    ex(16'hABCD, 0, 1);
    `CHK(pinOut[3], 1'b0)
    ex(16'hABCC, 0, 1);
    `CHK(pinOut[3], 1'b1)
    ex(16'h0000, 1, 1);
    sfr(8'h92, 8'h00, 1);
    sfr(8'h93, 8'h00, 1);
    sfr(8'hA3, 8'h00, 1);
  endtask : t_strobe
  task t_reboot;
    @(negedge clock) bootLow = 1;
    repeat (4) @(negedge clock);
    `CHK(rebootRequest, 1'b1)
    bootLow = 0;
    repeat (4) @(negedge clock);
    `CHK(rebootRequest, 1'b0)
  endtask : t_reboot
  initial begin
    @(negedge clock) resetn = 0;
    repeat (6) @(posedge clock);
    @(negedge clock) resetn = 1;
    repeat (3) @(negedge clock);
    t_reset();
    t_gpio();
    t_strobe();
    t_reboot();
    results();
  end
endmodule : tb_top
